// ---- nvd_pkg.sv ----
// Package for the nonvolatile data store access unit
package nvd_pkg;
  localparam int unsigned NVD_DEPTH = 1024;
  localparam int unsigned NVD_AW = 10;
  localparam int unsigned NVD_DW = 8;
  // Register offsets inside the I/O register space
  localparam logic [5:0] NVD_OFF_ADDR_HIGH = 6'h1f;
  localparam logic [5:0] NVD_OFF_ADDR_LOW = 6'h1e;
  localparam logic [5:0] NVD_OFF_DATA = 6'h1d;
  localparam logic [5:0] NVD_OFF_CONTROL = 6'h1c;
  // Control register bit positions
  localparam int unsigned NVD_BIT_READ = 0;
  localparam int unsigned NVD_BIT_WRITE = 1;
  localparam int unsigned NVD_BIT_MASTER = 2;
  localparam int unsigned NVD_BIT_RDY_IE = 3;
  localparam logic [7:0] NVD_CTRL_RESET = 8'h00;
  // Timing
  localparam int unsigned NVD_CLK_HZ = 125000000;
  localparam int unsigned NVD_OSC_HZ = 1000000;
  localparam int unsigned NVD_OSC_DIV = NVD_CLK_HZ / NVD_OSC_HZ;
  localparam int unsigned NVD_WRITE_OSC_CYCLES = 8448;
  localparam int unsigned NVD_MASTER_CYCLES = 4;
  localparam int unsigned NVD_READ_STALL = 4;
  localparam int unsigned NVD_WRITE_STALL = 2;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } nvd_io_req_type;

  typedef struct packed {
    logic [7:0] rdata;
    logic stall;
    logic ready_irq;
  } nvd_io_rsp_type;
endpackage : nvd_pkg

// ---- nvd_access.sv ----
// Nonvolatile data store with I/O register access, write timing and CPU stall
//
// Overview of operation
// - Store holds 1024 bytes in a space of its own.
// - Reads and writes move one byte at a time.
// - Address, data and control registers sit in I/O register space.
// - Writes are self-timed; write strobe bit shows completion.
// - A triggered read stalls the CPU four cycles, or two if a write starts in the same access.
// - A started write stalls the CPU two cycles.
// - Ten address bits select bytes 0 to 1023 linearly.
// - Address bits 15 to 10 read as zero.
// - Address field is not initialised at reset.
// - Write programs the data register byte at the address.
// - Read loads the addressed byte into the data register.
// - Writes without the enable sequence are ignored.
// - Master enable self-clears after four cycles; write needs it set.
// - Write strobe stays set during write, cleared by hardware after.
// - Read strobe returns data within the same instruction.
// - Write lasts 8448 cycles of a 1 MHz timing oscillator.
`timescale 1ns/1ps
`default_nettype none
module nvd_access (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire nvd_pkg::nvd_io_req_type io_req,
  output nvd_pkg::nvd_io_rsp_type io_rsp
);
  import nvd_pkg::*;

  localparam int unsigned OSCW = $clog2(NVD_OSC_DIV);
  localparam int unsigned WCW = $clog2(NVD_WRITE_OSC_CYCLES + 1);
  localparam logic [OSCW-1:0] OSC_LAST = OSCW'(NVD_OSC_DIV - 1);
  localparam logic [WCW-1:0] WR_LAST = WCW'(NVD_WRITE_OSC_CYCLES - 1);
  localparam logic [2:0] MASTER_LOAD = 3'(NVD_MASTER_CYCLES);
  localparam logic [2:0] RD_STALL = 3'(NVD_READ_STALL);
  localparam logic [2:0] WR_STALL = 3'(NVD_WRITE_STALL);
  // Independent write duration count for the timing check
  localparam int unsigned WR_TOTAL = NVD_WRITE_OSC_CYCLES * NVD_OSC_DIV;
  localparam int unsigned WTW = $clog2(WR_TOTAL + 1);
  localparam logic [WTW-1:0] WR_TOTAL_W = WTW'(WR_TOTAL);

  typedef enum logic [0:0] {ST_IDLE, ST_WRITING} nvd_state_type;

  function automatic logic hit(input nvd_io_req_type r, input logic [5:0] off);
    hit = r.wr && (r.addr == off);
  endfunction : hit

  logic [NVD_DW-1:0] mem [0:NVD_DEPTH-1];
  logic [NVD_AW-1:0] addr_ff, nxt_addr;
  logic [NVD_DW-1:0] data_ff, nxt_data;
  logic [2:0] master_ff, nxt_master;
  logic ie_ff, nxt_ie;
  logic [2:0] stall_ff, nxt_stall;
  nvd_state_type state_ff, nxt_state;
  logic [OSCW-1:0] osc_ff, nxt_osc;
  logic [WCW-1:0] wcnt_ff, nxt_wcnt;
  logic [NVD_AW-1:0] waddr_ff, nxt_waddr;
  logic [NVD_DW-1:0] wdata_ff, nxt_wdata;
  logic mem_we;
  logic [NVD_DW-1:0] rd_ff, nxt_rd;
  logic irq_ff, nxt_irq;
  logic halt_ff, nxt_halt;
  logic [WTW-1:0] wtime_ff, nxt_wtime;
  logic busy, rd_go, wr_go;
  logic [7:0] ctrl_rd;

  assign busy = (state_ff == ST_WRITING);
  // Read strobe only while idle
  assign rd_go = hit(io_req, NVD_OFF_CONTROL) && io_req.wdata[NVD_BIT_READ] && !busy;
  // Write only when master enable still live
  assign wr_go = hit(io_req, NVD_OFF_CONTROL) && io_req.wdata[NVD_BIT_WRITE]
                 && (master_ff != 3'h0) && !busy;

  assign ctrl_rd = {4'h0, ie_ff, (master_ff != 3'h0), busy, 1'b0};

  // Register file and sequencing
  always_comb begin
    nxt_addr = addr_ff;
    nxt_data = data_ff;
    nxt_master = master_ff;
    nxt_ie = ie_ff;
    nxt_stall = (stall_ff != 3'h0) ? stall_ff - 3'h1 : 3'h0;
    nxt_state = state_ff;
    nxt_osc = osc_ff;
    nxt_wcnt = wcnt_ff;
    nxt_waddr = waddr_ff;
    nxt_wdata = wdata_ff;
    mem_we = 1'b0;
    nxt_rd = 8'h00;
    if (master_ff != 3'h0) begin
      nxt_master = master_ff - 3'h1;
    end
    if (hit(io_req, NVD_OFF_ADDR_LOW) && !busy) begin
      nxt_addr[7:0] = io_req.wdata;
    end
    if (hit(io_req, NVD_OFF_ADDR_HIGH) && !busy) begin
      nxt_addr[NVD_AW-1:8] = io_req.wdata[NVD_AW-9:0];
    end
    if (hit(io_req, NVD_OFF_DATA)) begin
      nxt_data = io_req.wdata;
    end
    if (hit(io_req, NVD_OFF_CONTROL)) begin
      nxt_ie = io_req.wdata[NVD_BIT_RDY_IE];
      if (io_req.wdata[NVD_BIT_MASTER] && !io_req.wdata[NVD_BIT_WRITE]) begin
        nxt_master = MASTER_LOAD;
      end
    end
    if (rd_go) begin
      nxt_data = mem[addr_ff];
      nxt_stall = RD_STALL;
    end
    if (wr_go) begin
      nxt_state = ST_WRITING;
      nxt_waddr = addr_ff;
      nxt_wdata = data_ff;
      nxt_osc = '0;
      nxt_wcnt = '0;
      nxt_master = 3'h0;
      nxt_stall = WR_STALL;
    end
    if (busy) begin
      nxt_osc = (osc_ff == OSC_LAST) ? '0 : osc_ff + OSCW'(1);
      if (osc_ff == OSC_LAST) begin
        nxt_wcnt = wcnt_ff + WCW'(1);
        if (wcnt_ff == WR_LAST) begin
          mem_we = 1'b1;
          nxt_state = ST_IDLE;
        end
      end
    end
    unique case (io_req.addr)
      NVD_OFF_ADDR_HIGH: nxt_rd = {6'h00, addr_ff[NVD_AW-1:8]};
      NVD_OFF_ADDR_LOW: nxt_rd = addr_ff[7:0];
      NVD_OFF_DATA: nxt_rd = nxt_data;
      NVD_OFF_CONTROL: nxt_rd = ctrl_rd;
      default: nxt_rd = 8'h00;
    endcase
    nxt_irq = nxt_ie && (nxt_state == ST_IDLE);
    // Halt output registered so the core sees a clean level
    nxt_halt = (nxt_stall != 3'h0);
    nxt_wtime = busy ? wtime_ff + WTW'(1) : '0;
  end

  // Address and data carry no reset value
  always_ff @(posedge ref_clk) begin
    addr_ff <= nxt_addr;
    data_ff <= nxt_data;
    waddr_ff <= nxt_waddr;
    wdata_ff <= nxt_wdata;
    if (mem_we) begin
      mem[waddr_ff] <= wdata_ff;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      master_ff <= 3'h0;
      ie_ff <= NVD_CTRL_RESET[NVD_BIT_RDY_IE];
      stall_ff <= 3'h0;
      state_ff <= ST_IDLE;
      osc_ff <= '0;
      wcnt_ff <= '0;
      rd_ff <= 8'h00;
      irq_ff <= 1'b0;
      halt_ff <= 1'b0;
      wtime_ff <= '0;
    end else begin
      master_ff <= nxt_master;
      ie_ff <= nxt_ie;
      stall_ff <= nxt_stall;
      state_ff <= nxt_state;
      osc_ff <= nxt_osc;
      wcnt_ff <= nxt_wcnt;
      rd_ff <= nxt_rd;
      irq_ff <= nxt_irq;
      halt_ff <= nxt_halt;
      wtime_ff <= nxt_wtime;
    end
  end

  assign io_rsp.rdata = rd_ff;
  assign io_rsp.stall = halt_ff;
  assign io_rsp.ready_irq = irq_ff;

  a_master_expiry: assert property (@(posedge ref_clk) disable iff (!resetn)
    (master_ff == MASTER_LOAD) |-> ##4 (master_ff == 3'h0))
    else $error("master enable did not clear after four cycles");
  a_read_stall_len: assert property (@(posedge ref_clk) disable iff (!resetn)
    rd_go |=> io_rsp.stall [*4] ##1 !io_rsp.stall)
    else $error("read stall not four cycles");
  a_write_stall_len: assert property (@(posedge ref_clk) disable iff (!resetn)
    wr_go |=> io_rsp.stall [*2] ##1 !io_rsp.stall)
    else $error("write stall not two cycles");
  a_write_needs_master: assert property (@(posedge ref_clk) disable iff (!resetn)
    (!busy && $past(master_ff) == 3'h0 && master_ff == 3'h0) |=> !busy || $past(busy))
    else $error("write started without master enable");
  a_write_busy_span: assert property (@(posedge ref_clk) disable iff (!resetn)
    wr_go |=> busy [*8])
    else $error("write strobe dropped early");
  a_write_done_len: assert property (@(posedge ref_clk) disable iff (!resetn)
    $fell(busy) |-> (wtime_ff == WR_TOTAL_W))
    else $error("write ended before 8448 oscillator cycles");
  a_addr_frozen: assert property (@(posedge ref_clk) disable iff (!resetn)
    $past(busy) && busy |-> $stable(addr_ff))
    else $error("address changed during write");
  a_ready_irq: assert property (@(posedge ref_clk) disable iff (!resetn)
    io_rsp.ready_irq == (ie_ff && !busy))
    else $error("ready request wrong");
  a_addr_high_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
    ($past(io_req.addr) == NVD_OFF_ADDR_HIGH) |-> (io_rsp.rdata[7:2] == 6'h00))
    else $error("address high reserved bits not zero");
  a_master_arm: assert property (@(posedge ref_clk) disable iff (!resetn)
    (hit(io_req, NVD_OFF_CONTROL) && io_req.wdata[NVD_BIT_MASTER] && !io_req.wdata[NVD_BIT_WRITE])
    |=> (master_ff == MASTER_LOAD)) else $error("master enable not armed");
  a_busy_read_ignored: assert property (@(posedge ref_clk) disable iff (!resetn)
    (busy && stall_ff == 3'h0 && hit(io_req, NVD_OFF_CONTROL) && io_req.wdata[NVD_BIT_READ])
    |=> !io_rsp.stall) else $error("read strobe taken during write");
endmodule : nvd_access
`default_nettype wire

// ---- nvd_cpu_model.sv ----
// CPU core model issuing I/O register accesses
`timescale 1ns/1ps
`default_nettype none
module nvd_cpu_model (
  input wire logic ref_clk,
  output var nvd_pkg::nvd_io_req_type io_req,
  input wire nvd_pkg::nvd_io_rsp_type io_rsp
);
  import nvd_pkg::*;
  initial io_req = '0;
  // No new access while the core is halted
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    while (io_rsp.stall !== 1'b0) @(posedge ref_clk);
    io_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    io_req.wr <= 1'b0;
    io_req.wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    while (io_rsp.stall !== 1'b0) @(posedge ref_clk);
    io_req.rd <= 1'b1;
    io_req.addr <= a;
    @(posedge ref_clk);
    io_req.rd <= 1'b0;
    #1 d = io_rsp.rdata;
  endtask : rd
endmodule : nvd_cpu_model
`default_nettype wire

// ---- tb.sv ----
// Self-checking testbench for the nonvolatile store access unit
`timescale 1ns/1ps
`default_nettype none
module tb;
  import nvd_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  nvd_io_req_type io_req;
  nvd_io_rsp_type io_rsp;
  logic [7:0] d;
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  always #4 ref_clk = ~ref_clk;
  nvd_access dut_u (.ref_clk(ref_clk), .resetn(resetn), .io_req(io_req), .io_rsp(io_rsp));
  nvd_cpu_model cpu_u (.ref_clk(ref_clk), .io_req(io_req), .io_rsp(io_rsp));
  task automatic summarize;
    if (n_errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // Halted cycles seen after the taken edge
  task automatic stall_cnt(output logic [7:0] n);
    n = 8'h00;
    repeat (8) begin
      #1 if (io_rsp.stall === 1'b1) n = n + 8'h01;
      @(posedge ref_clk);
    end
  endtask : stall_cnt
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      summarize();
    end
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    cpu_u.rd(NVD_OFF_CONTROL, d);
    chk(d, NVD_CTRL_RESET);
    chk({7'h00, io_rsp.ready_irq}, 8'h00);
    cpu_u.wr(NVD_OFF_ADDR_HIGH, 8'hff);
    cpu_u.wr(NVD_OFF_ADDR_LOW, 8'h5a);
    cpu_u.rd(NVD_OFF_ADDR_HIGH, d);
    chk(d, 8'h03);
    cpu_u.rd(NVD_OFF_ADDR_LOW, d);
    chk(d, 8'h5a);
    cpu_u.wr(NVD_OFF_CONTROL, 8'h01);
    stall_cnt(d);
    chk(d, 8'(NVD_READ_STALL));
    cpu_u.wr(NVD_OFF_DATA, 8'hc3);
    cpu_u.rd(NVD_OFF_DATA, d);
    chk(d, 8'hc3);
    cpu_u.wr(NVD_OFF_CONTROL, 8'h04);
    cpu_u.rd(NVD_OFF_CONTROL, d);
    chk(d, 8'h04);
    repeat (4) @(posedge ref_clk);
    cpu_u.rd(NVD_OFF_CONTROL, d);
    chk(d, 8'h00);
    cpu_u.wr(NVD_OFF_CONTROL, 8'h02);
    cpu_u.rd(NVD_OFF_CONTROL, d);
    chk(d, 8'h00);
    cpu_u.wr(NVD_OFF_CONTROL, 8'h06);
    cpu_u.rd(NVD_OFF_CONTROL, d);
    chk(d, 8'h00);
    cpu_u.wr(NVD_OFF_CONTROL, 8'h08);
    cpu_u.rd(NVD_OFF_CONTROL, d);
    chk(d, 8'h08);
    chk({7'h00, io_rsp.ready_irq}, 8'h01);
    cpu_u.wr(NVD_OFF_CONTROL, 8'h0c);
    cpu_u.wr(NVD_OFF_CONTROL, 8'h0a);
    stall_cnt(d);
    chk(d, 8'(NVD_WRITE_STALL));
    cpu_u.rd(NVD_OFF_CONTROL, d);
    chk(d, 8'h0a);
    chk({7'h00, io_rsp.ready_irq}, 8'h00);
    chk(dut_u.waddr_ff[7:0], 8'h5a);
    chk({6'h00, dut_u.waddr_ff[9:8]}, 8'h03);
    chk(dut_u.wdata_ff, 8'hc3);
    cpu_u.wr(NVD_OFF_ADDR_LOW, 8'h00);
    cpu_u.rd(NVD_OFF_ADDR_LOW, d);
    chk(d, 8'h5a);
    cpu_u.wr(NVD_OFF_CONTROL, 8'h0b);
    stall_cnt(d);
    chk(d, 8'h00);
    summarize();
  end
endmodule : tb
`default_nettype wire
